// ===== include/flrb_consts.vh
// Constants for the fuse/lock readback and boot map block
// Assumes inclusion by bare name from design files
`ifndef FLRB_CONSTS_VH
`define FLRB_CONSTS_VH
`define FLRB_ADDR_CTRL 12'h000
`define FLRB_ADDR_ZPTR 12'h004
`define FLRB_ADDR_FUSE 12'h008
`define FLRB_ADDR_LOCK 12'h00c
`define FLRB_ADDR_STAT 12'h010
`define FLRB_ADDR_LPM 12'h014
`define FLRB_ADDR_MEMD 12'h018
`define FLRB_BIT_STORE_PROGRAM_ENABLE 0
`define FLRB_BIT_PGERS 1
`define FLRB_BIT_PGWRT 2
`define FLRB_BIT_LOCK_READ_SELECT 3
`define FLRB_BIT_REEN 4
`define FLRB_BIT_BUSY 6
`define FLRB_Z_LOCK 13'h0001
`define FLRB_Z_FLOW 13'h0000
`define FLRB_Z_FHIGH 13'h0003
`define FLRB_Z_FEXT 13'h0002
`define FLRB_LPM_WIN 3'd3
`define FLRB_SPM_WIN 3'd4
`define FLRB_CLK_KHZ 25000
`define FLRB_TMIN_US 3700
`define FLRB_TMAX_US 4500
`define FLRB_WRITE_CYC ((`FLRB_TMIN_US * `FLRB_CLK_KHZ + 999) / 1000)
`define FLRB_BOOT_11 12'hf80
`define FLRB_BOOT_10 12'hf00
`define FLRB_BOOT_01 12'he00
`define FLRB_BOOT_00 12'hc00
`define FLRB_NO_CONCURRENT_READ_SECTION_START 12'hc00
`define FLRB_LOCK_RST 8'hff
`define FLRB_FUSE_RST 24'hffffff
`endif

// ===== design/flrb_write_timer.v
// Flash write duration timer
// Assumes a start pulse from the top; gives back a one-cycle done tick
`timescale 1ns/100ps
`include "flrb_consts.vh"
module flrb_write_timer #(
	parameter WRITE_CYC = `FLRB_WRITE_CYC
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire start_i,
	output reg busy_o,
	output reg done_o
);
	reg [19:0] cnt_reg;
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_reg <= 20'h00000;
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (start_i && !busy_o) begin
				cnt_reg <= WRITE_CYC[19:0] - 20'h00001;
				busy_o <= 1'b1;
			end else if (busy_o) begin
				if (cnt_reg == 20'h00000) begin
					busy_o <= 1'b0;
					done_o <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 20'h00001;
				end
			end
		end
	end
endmodule

// ===== design/flrb_top.v
// Fuse and lock readback, boot map decode and self-program control
// Assumes an APB master; flash array outside supplies program bytes
//
// Behaviour
// - Lock byte returned for pointer one, armed
// - Lock byte layout boot bits 5:2, memory 1:0
// - Arm bits self-clear after read or timeout
// - Disarmed load reads ordinary program byte
// - Pointer zero returns low fuse byte
// - Pointer three returns high fuse byte
// - Pointer two returns extended fuse bits 3:0
// - Programmed reads zero, unprogrammed one
// - Reset aborts a running flash write; timer cleared by nrst_i
// - Flash writes timed 3.7 to 4.5 ms
// - Boot size select picks boot start
// - READ_WHILE_WRITE_SECTION below 0xC00, NO_CONCURRENT_READ_SECTION above
// - Twelve bit counter, 32 word pages
// - Page index from pointer bits 12:6
// - Word index from pointer bits 5:1
// - Ignore pointer 15:13; bit 0 selects byte in fuse and lock readback only
// - Erase pattern then store starts erase
// - Busy flag set by an erase or write issued with lock read select clear, held until a REEN write made in idle after the timer finishes
`timescale 1ns/100ps
`include "flrb_consts.vh"
module flrb_top #(
	parameter WRITE_CYC = `FLRB_WRITE_CYC
) (
	input wire clk_sys_i,
	input wire nrst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [7:0] fuse_low_byte_i,
	input wire [7:0] fuse_high_byte_i,
	input wire [7:0] fuse_extended_byte_i,
	input wire [7:0] lock_bits_i,
	input wire eeprom_write_active_i,
	input wire [7:0] flash_byte_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o,
	output reg [11:0] flash_addr_o,
	output reg flash_erase_o,
	output reg flash_write_o,
	output reg [6:0] page_index_field_o,
	output reg [4:0] word_index_field_o,
	output reg [11:0] boot_start_o,
	output reg concurrent_section_busy_flag_o
);
	reg rst_s1_reg;
	reg rst_n;
	always @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_s1_reg <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_n <= rst_s1_reg;
		end
	end

	function [11:0] boot_start_f;
		input [1:0] sz;
		begin
			case (sz)
				2'b11: boot_start_f = `FLRB_BOOT_11;
				2'b10: boot_start_f = `FLRB_BOOT_10;
				2'b01: boot_start_f = `FLRB_BOOT_01;
				default: boot_start_f = `FLRB_BOOT_00;
			endcase
		end
	endfunction

	function is_no_concurrent_read_section_f;
		input [6:0] page;
		begin
			is_no_concurrent_read_section_f = ({page, 5'h00} >= `FLRB_NO_CONCURRENT_READ_SECTION_START);
		end
	endfunction

	localparam ST_IDLE = 3'b001;
	localparam ST_ARMED = 3'b010;
	localparam ST_PROG = 3'b100;

	reg [2:0] state_reg;
	reg [2:0] win_reg;
	reg [4:0] ctrl_reg;
	reg [15:0] zptr_reg;
	reg [7:0] lpm_data_reg;
	reg rww_busy_reg;
	reg [6:0] op_page_reg;
	reg op_no_concurrent_read_section_reg;
	reg [7:0] lock_cap_reg;
	reg [23:0] fuse_cap_reg;
	reg cap_done_reg;
	reg timer_start;
	wire timer_busy;
	wire timer_done;

	wire apb_wr = psel_i && penable_i && pwrite_i && pready_o;
	wire apb_rd = psel_i && penable_i && !pwrite_i && pready_o;
	wire [12:0] zsel = zptr_reg[12:0];
	wire armed_rb = (state_reg == ST_ARMED) && ctrl_reg[`FLRB_BIT_LOCK_READ_SELECT];
	wire spm_issue = apb_wr && (paddr_i == `FLRB_ADDR_CTRL) && pwdata_i[7];

	// Straps caught once after reset release; flash keeps its own
	always @(posedge clk_sys_i) begin
		if (!rst_n) begin
			cap_done_reg <= 1'b0;
			lock_cap_reg <= `FLRB_LOCK_RST;
			fuse_cap_reg <= `FLRB_FUSE_RST;
		end else if (!cap_done_reg) begin
			cap_done_reg <= 1'b1;
			lock_cap_reg <= lock_bits_i;
			fuse_cap_reg <= {fuse_extended_byte_i, fuse_high_byte_i, fuse_low_byte_i};
		end
	end

	// Readback mux: raw fuse levels, 0 programmed 1 not
	reg [7:0] rb_data;
	reg rb_hit;
	always @* begin
		rb_hit = 1'b1;
		case (zsel)
			`FLRB_Z_LOCK: rb_data = {2'b11, lock_cap_reg[5:0]};
			`FLRB_Z_FLOW: rb_data = fuse_cap_reg[7:0];
			`FLRB_Z_FHIGH: rb_data = fuse_cap_reg[15:8];
			`FLRB_Z_FEXT: rb_data = {4'hf, fuse_cap_reg[19:16]};
			default: begin
				rb_data = flash_byte_i;
				rb_hit = 1'b0;
			end
		endcase
	end

	wire lpm_issue = apb_rd && (paddr_i == `FLRB_ADDR_LPM);

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			win_reg <= 3'd0;
			ctrl_reg <= 5'h00;
			zptr_reg <= 16'h0000;
			lpm_data_reg <= 8'h00;
			rww_busy_reg <= 1'b0;
			op_page_reg <= 7'h00;
			op_no_concurrent_read_section_reg <= 1'b0;
			timer_start <= 1'b0;
			flash_erase_o <= 1'b0;
			flash_write_o <= 1'b0;
		end else begin
			timer_start <= 1'b0;
			flash_erase_o <= 1'b0;
			flash_write_o <= 1'b0;
			if (apb_wr && paddr_i == `FLRB_ADDR_ZPTR)
				zptr_reg <= pwdata_i[15:0];
			case (state_reg)
				ST_IDLE: begin
					if (apb_wr && paddr_i == `FLRB_ADDR_CTRL && pwdata_i[`FLRB_BIT_STORE_PROGRAM_ENABLE]
						&& !eeprom_write_active_i && !timer_busy) begin
						ctrl_reg <= pwdata_i[4:0];
						win_reg <= 3'd0;
						state_reg <= ST_ARMED;
					end else if (apb_wr && paddr_i == `FLRB_ADDR_CTRL && pwdata_i[`FLRB_BIT_REEN]
						&& !timer_busy) begin
						rww_busy_reg <= 1'b0;
					end
				end
				ST_ARMED: begin
					win_reg <= win_reg + 3'd1;
					if (lpm_issue) begin
						lpm_data_reg <= (armed_rb && rb_hit) ? rb_data : flash_byte_i;
						if (armed_rb) begin
							ctrl_reg <= 5'h00;
							state_reg <= ST_IDLE;
						end
					end else if (spm_issue) begin
						if (ctrl_reg[`FLRB_BIT_PGERS] || ctrl_reg[`FLRB_BIT_PGWRT]
							|| ctrl_reg[`FLRB_BIT_LOCK_READ_SELECT]) begin
							op_page_reg <= zptr_reg[12:6];
							op_no_concurrent_read_section_reg <= is_no_concurrent_read_section_f(zptr_reg[12:6]);
							timer_start <= 1'b1;
							flash_erase_o <= ctrl_reg[`FLRB_BIT_PGERS];
							flash_write_o <= ctrl_reg[`FLRB_BIT_PGWRT];
							if (!ctrl_reg[`FLRB_BIT_LOCK_READ_SELECT])
								rww_busy_reg <= 1'b1;
							state_reg <= ST_PROG;
						end else begin
							ctrl_reg <= 5'h00;
							state_reg <= ST_IDLE;
						end
					end else if (win_reg >= `FLRB_SPM_WIN - 3'd1) begin
						ctrl_reg <= 5'h00;
						state_reg <= ST_IDLE;
					end else if (armed_rb && win_reg >= `FLRB_LPM_WIN - 3'd1) begin
						ctrl_reg <= 5'h00;
						state_reg <= ST_IDLE;
					end
				end
				ST_PROG: begin
					if (timer_done) begin
						ctrl_reg <= 5'h00;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
			if (!armed_rb && lpm_issue && state_reg != ST_ARMED)
				lpm_data_reg <= flash_byte_i;
		end
	end

	// Timer keeps its own reset away from the flash path
	flrb_write_timer #(
		.WRITE_CYC(WRITE_CYC)
	) u_timer (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(nrst_i),
		.start_i(timer_start),
		.busy_o(timer_busy),
		.done_o(timer_done)
	);

	// APB read data, one wait state answer
	reg [31:0] rd_mux;
	always @* begin
		case (paddr_i)
			`FLRB_ADDR_CTRL: rd_mux = {24'h000000, 1'b0, rww_busy_reg, 1'b0, ctrl_reg};
			`FLRB_ADDR_ZPTR: rd_mux = {16'h0000, zptr_reg};
			`FLRB_ADDR_FUSE: rd_mux = {8'h00, fuse_cap_reg};
			`FLRB_ADDR_LOCK: rd_mux = {24'h000000, lock_cap_reg};
			`FLRB_ADDR_STAT: rd_mux = {29'h00000000, timer_busy, op_no_concurrent_read_section_reg, eeprom_write_active_i};
			`FLRB_ADDR_LPM: rd_mux = {24'h000000, lpm_data_reg};
			default: rd_mux = 32'h00000000;
		endcase
	end

	wire known = (paddr_i == `FLRB_ADDR_CTRL) || (paddr_i == `FLRB_ADDR_ZPTR)
		|| (paddr_i == `FLRB_ADDR_FUSE) || (paddr_i == `FLRB_ADDR_LOCK)
		|| (paddr_i == `FLRB_ADDR_STAT) || (paddr_i == `FLRB_ADDR_LPM);

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h00000000;
			flash_addr_o <= 12'h000;
			page_index_field_o <= 7'h00;
			word_index_field_o <= 5'h00;
			boot_start_o <= `FLRB_BOOT_00;
			concurrent_section_busy_flag_o <= 1'b0;
		end else begin
			pready_o <= psel_i && penable_i && !pready_o;
			pslverr_o <= psel_i && penable_i && !pready_o && !known;
			if (psel_i && penable_i && !pready_o)
				prdata_o <= rd_mux;
			flash_addr_o <= zptr_reg[12:1];
			page_index_field_o <= (state_reg == ST_PROG) ? op_page_reg : zptr_reg[12:6];
			word_index_field_o <= zptr_reg[5:1];
			boot_start_o <= boot_start_f(fuse_cap_reg[18:17]);
			concurrent_section_busy_flag_o <= rww_busy_reg;
		end
	end
endmodule

// ===== tb/flrb_flash_model.sv
// Flash array stand-in: one byte for each word address
// Assumes the top drives its flash address continuously
`timescale 1ns/100ps
module flrb_flash_model (
	input wire [11:0] flash_addr_i,
	output wire [7:0] flash_byte_o
);
	assign flash_byte_o = flash_addr_i[7:0] ^ 8'ha5;
endmodule

// ===== tb/flrb_top_assertions.sv
// Port checker for the readback and boot map top
// Assumes binding onto flrb_top
`timescale 1ns/100ps
module flrb_top_assertions (
	input wire clk_sys_i,
	input wire nrst_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire pready_o,
	input wire pslverr_o,
	input wire flash_erase_o,
	input wire flash_write_o,
	input wire [6:0] page_index_field_o,
	input wire [11:0] boot_start_o,
	input wire concurrent_section_busy_flag_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	wire reen = psel_i && pwrite_i && paddr_i == 12'h000 && pwdata_i[4];
	wire busy = concurrent_section_busy_flag_o;
	property p_rdy; pready_o |=> !pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("ready held too long");
	property p_rdy_req; pready_o |-> psel_i && penable_i; endproperty
	a_rdy_req: assert property (p_rdy_req) else $error("ready outside access");
	property p_err; pslverr_o |-> pready_o; endproperty
	a_err: assert property (p_err) else $error("error without ready");
	property p_ers; flash_erase_o |=> !flash_erase_o; endproperty
	a_ers: assert property (p_ers) else $error("erase pulse too long");
	property p_one; !(flash_erase_o && flash_write_o); endproperty
	a_one: assert property (p_one) else $error("erase and write together");
	property p_boot; boot_start_o inside {12'hf80, 12'hf00, 12'he00, 12'hc00}; endproperty
	a_boot: assert property (p_boot) else $error("bad boot start");
	property p_fell; $fell(busy) |-> $past(reen) || $past(reen, 2); endproperty
	a_fell: assert property (p_fell) else $error("busy cleared early");
	property p_rww; flash_erase_o && page_index_field_o < 7'd96 |-> ##[0:2] busy; endproperty
	a_rww: assert property (p_rww) else $error("busy not set");
	c_ers: cover property (flash_erase_o);
	c_err: cover property (pslverr_o);
	c_fell: cover property ($fell(busy));
endmodule
bind flrb_top flrb_top_assertions u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .flash_erase_o(flash_erase_o), .flash_write_o(flash_write_o),
	.page_index_field_o(page_index_field_o), .boot_start_o(boot_start_o),
	.concurrent_section_busy_flag_o(concurrent_section_busy_flag_o));

// ===== tb/tb_top.sv
// Self-checking bench: readback, disarm, erase and busy flow
// Assumes design, flash model and checker compiled first
`timescale 1ns/100ps
`include "flrb_consts.vh"
module tb_top;
	reg clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err, ee = 1'b0;
	wire [6:0] pg;
	wire [4:0] wd;
	reg [11:0] pa = 12'h000;
	reg [31:0] pd = 32'h0, rd, z;
	reg [7:0] f_lo, f_hi, f_ex, lk;
	reg [7:0] q[$];
	wire [31:0] prd;
	wire rdy, perr, ers, busy;
	wire [11:0] fa, boot;
	wire [7:0] fb;
	integer seed = 89087, n_fail = 0, comparisons = 0, n_ers = 0, k;
	always #20 clk = ~clk;
	always @(posedge clk) if (ers) n_ers <= n_ers + 1;
	flrb_top #(.WRITE_CYC(20)) i_flrb_top (.clk_sys_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pd), .fuse_low_byte_i(f_lo), .fuse_high_byte_i(f_hi),
		.fuse_extended_byte_i(f_ex), .lock_bits_i(lk), .eeprom_write_active_i(ee), .flash_byte_i(fb),
		.prdata_o(prd), .pready_o(rdy), .pslverr_o(perr), .flash_addr_o(fa), .flash_erase_o(ers),
		.flash_write_o(), .page_index_field_o(pg), .word_index_field_o(wd), .boot_start_o(boot),
		.concurrent_section_busy_flag_o(busy));
	flrb_flash_model i_flrb_flash_model (.flash_addr_i(fa), .flash_byte_o(fb));
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("[FAIL] %0s exp %h got %h", nm, e, g);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1'b1;
			pwr <= w;
			pa <= a;
			pd <= d;
			@(posedge clk);
			pen <= 1'b1;
			@(posedge clk);
			while (rdy !== 1'b1) @(posedge clk);
			rd = prd;
			err = perr;
			pen <= 1'b0;
		end
	endtask
	task idle(input integer n);
		begin
			psel <= 1'b0;
			repeat (n) @(posedge clk);
		end
	endtask
	task load(input arm);
		begin
			apb(1'b0, `FLRB_ADDR_LPM, 32'h0);
			if (q.size() > 0) chk("load", {24'h0, q.pop_front()}, rd);
			case (arm ? z[12:0] : 13'h1fff)
				13'h0000: q.push_back(f_lo);
				13'h0001: q.push_back({2'b11, lk[5:0]});
				13'h0002: q.push_back({4'hf, f_ex[3:0]});
				13'h0003: q.push_back(f_hi);
				default: q.push_back(z[8:1] ^ 8'ha5);
			endcase
		end
	endtask
	task give_verdict;
		begin
			if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
			else $display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		#400000;
		n_fail = n_fail + 1;
		give_verdict;
	end
	initial begin
		{f_lo, f_hi, f_ex, lk} = $random(seed);
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		idle(6);
		chk("boot", f_ex[2:1] == 3 ? 12'hf80 : f_ex[2:1] == 2 ? 12'hf00 : f_ex[2:1] == 1 ? 12'he00 : 12'hc00, boot);
		for (k = 0; k < 6; k = k + 1) begin
			z = (k == 4) ? 5 : (k == 5) ? 1 : k;
			z = z | (($random(seed) & 7) << 13);
			apb(1'b1, `FLRB_ADDR_ZPTR, z);
			apb(1'b1, `FLRB_ADDR_CTRL, 32'h09);
			if (k == 5) idle(6);
			load(k != 5);
			load(1'b0);
			load(1'b0);
			idle(1 + ($random(seed) & 3));
		end
		ee <= 1'b1;
		apb(1'b1, `FLRB_ADDR_CTRL, 32'h09);
		ee <= 1'b0;
		load(1'b0);
		load(1'b0);
		apb(1'b1, `FLRB_ADDR_ZPTR, 32'h140);
		apb(1'b1, `FLRB_ADDR_CTRL, 32'h03);
		apb(1'b1, `FLRB_ADDR_CTRL, 32'h83);
		idle(3);
		chk("erase", 1, n_ers);
		chk("page", 5, pg);
		chk("word", 0, wd);
		chk("faddr", 12'h0a0, fa);
		chk("busy", 1, busy);
		idle(40);
		chk("busy", 1, busy);
		apb(1'b1, `FLRB_ADDR_CTRL, 32'h10);
		idle(3);
		chk("busy", 0, busy);
		apb(1'b0, 12'h020, 32'h0);
		chk("err", 1, err);
		chk("rdata", 0, rd);
		idle(1);
		give_verdict;
	end
endmodule
